/* common/irq_map_pkg.sv */
// Constants, types and vector arithmetic for the interrupt vector map
`default_nettype none
package irq_map_pkg;
  localparam int IRQ_COUNT  = 25;
  localparam int IRQ_W      = 5;
  localparam int ADDR_W     = 24;
  localparam int ADV_EVENTS = 5;

  typedef logic [ADDR_W-1:0]    vec_addr_t;
  typedef logic [IRQ_COUNT-1:0] irq_set_t;
  typedef logic [IRQ_W-1:0]     irq_num_t;

  localparam vec_addr_t VEC_RESET = 24'h008000;
  localparam vec_addr_t VEC_TRAP  = 24'h008004;
  localparam vec_addr_t VEC_IRQ0  = 24'h008008;
  localparam int        VEC_SHIFT = 2;

  localparam irq_num_t IRQ_TOP    = 5'h00;
  localparam irq_num_t IRQ_AWU    = 5'h01;
  localparam irq_num_t IRQ_CLK    = 5'h02;
  localparam irq_num_t IRQ_PORT_A = 5'h03;
  localparam irq_num_t IRQ_PORT_B = 5'h04;
  localparam irq_num_t IRQ_PORT_C = 5'h05;
  localparam irq_num_t IRQ_PORT_D = 5'h06;
  localparam irq_num_t IRQ_PORT_E = 5'h07;
  localparam irq_num_t IRQ_SPI    = 5'h0a;
  localparam irq_num_t IRQ_ADV_UP = 5'h0b;
  localparam irq_num_t IRQ_ADV_CC = 5'h0c;
  localparam irq_num_t IRQ_GEN_UP = 5'h0d;
  localparam irq_num_t IRQ_GEN_CC = 5'h0e;
  localparam irq_num_t IRQ_SER_TX = 5'h11;
  localparam irq_num_t IRQ_SER_RX = 5'h12;
  localparam irq_num_t IRQ_I2C    = 5'h13;
  localparam irq_num_t IRQ_CONV   = 5'h16;
  localparam irq_num_t IRQ_BASIC  = 5'h17;
  localparam irq_num_t IRQ_FLASH  = 5'h18;

  // Requests 8, 9, 15, 16, 20, 21
  localparam irq_set_t RESERVED_MASK   = 25'h0318300;
  // Ports A-E, SPI, I2C
  localparam irq_set_t WAKE_HALT_MASK  = 25'h00804f8;
  // Same plus auto-wakeup
  localparam irq_set_t WAKE_AHALT_MASK = 25'h00804fa;
  localparam logic     WAKE_AT_RESET   = 1'b1;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b01,
    ST_OFFER = 2'b10
  } offer_state_t;

  function automatic vec_addr_t irq_vector(input irq_num_t n);
    irq_vector = VEC_IRQ0 + (vec_addr_t'(n) << VEC_SHIFT);
  endfunction : irq_vector

  function automatic irq_set_t irq_onehot(input irq_num_t n);
    irq_onehot = irq_set_t'(1) << n;
  endfunction : irq_onehot
endpackage : irq_map_pkg
`default_nettype wire

/* hdl/irq_lowest_pick.sv */
// Finds the lowest-numbered set bit of a request vector
`default_nettype none
module irq_lowest_pick #(
  parameter int N = 25,
  parameter int W = 5
) (
  // Requests
  input  wire logic [N-1:0] req,
  // Result
  output logic              found,
  output logic [W-1:0]      idx
);
  if (N < 1 || N > (1 << W)) begin : g_chk
    $error("irq_lowest_pick: N does not fit in W bits");
  end

  always_comb begin
    found = 1'b0;
    idx   = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (req[i]) begin
        found = 1'b1;
        idx   = W'(i);
      end
    end
  end
endmodule : irq_lowest_pick
`default_nettype wire

/* hdl/irq_wake_gate.sv */
// Decides whether live source events wake the core from low power
`default_nettype none
module irq_wake_gate
  import irq_map_pkg::*;
(
  // Sources
  input  wire irq_map_pkg::irq_set_t src,
  input  wire logic                  port_a_pin1,
  // Core mode
  input  wire logic                  halt_mode,
  input  wire logic                  active_halt_mode,
  // Result
  output logic                       wake_req
);
  irq_set_t wake_src;
  logic     halt_hit;
  logic     ahalt_hit;

  assign wake_src = src & ~(irq_onehot(IRQ_PORT_A) &
                            {IRQ_COUNT{port_a_pin1}});
  assign halt_hit  = |(wake_src & WAKE_HALT_MASK);
  assign ahalt_hit = |(wake_src & WAKE_AHALT_MASK);
  assign wake_req  = (halt_mode & halt_hit) |
                     (active_halt_mode & ahalt_hit);
endmodule : irq_wake_gate
`default_nettype wire

/* hdl/irq_vector_wakeup_map.sv */
// Interrupt vector selection and low-power wakeup for the core
`default_nettype none
module irq_vector_wakeup_map
  import irq_map_pkg::*;
(
  // Clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  sys_rst,
  // Pin and wakeup sources
  input  wire logic                  top_level_pin_irq,
  input  wire logic                  auto_wakeup_unit,
  input  wire logic                  clock_ctrl_irq,
  // Port external interrupts
  input  wire logic                  port_a_pin_irq,
  input  wire logic                  port_a_pin1,
  input  wire logic                  port_b_pin_irq,
  input  wire logic                  port_c_pin_irq,
  input  wire logic                  port_d_pin_irq,
  input  wire logic                  port_e_pin_irq,
  // Serial interfaces
  input  wire logic                  spi_end_irq,
  input  wire logic                  serial_port_tx_irq,
  input  wire logic                  serial_port_rx_irq,
  input  wire logic                  i2c_irq,
  // Timers
  input  wire logic [ADV_EVENTS-1:0] advanced_timer_upd_irq,
  input  wire logic                  advanced_timer_cc_irq,
  input  wire logic                  general_timer_upd_irq,
  input  wire logic                  general_timer_cc_irq,
  input  wire logic                  basic_timer_upd_irq,
  // Converter and flash
  input  wire logic                  analog_converter_eoc_irq,
  input  wire logic                  analog_converter_wdg_irq,
  input  wire logic                  end_of_programming,
  input  wire logic                  protected_page_write_attempt,
  // Core side
  input  wire irq_map_pkg::irq_set_t irq_enable,
  input  wire logic                  trap_req,
  input  wire logic                  halt_mode,
  input  wire logic                  active_halt_mode,
  input  wire logic                  vec_ack,
  // Vector offer
  output logic                       vec_valid,
  output irq_map_pkg::vec_addr_t     vec_addr,
  output irq_map_pkg::irq_num_t      vec_irq_num,
  output logic                       vec_is_reset,
  output logic                       vec_is_trap,
  output logic                       wake
);
  offer_state_t state_r;
  offer_state_t state_nxt;
  irq_set_t     src;
  irq_set_t     pend_r;
  irq_set_t     pend_nxt;
  irq_set_t     pend_en;
  irq_set_t     ack_clr;
  logic         reset_pend_r;
  logic         reset_pend_nxt;
  logic         trap_pend_r;
  logic         trap_pend_nxt;
  logic         pick_found;
  irq_num_t     pick_idx;
  logic         take;
  logic         offer_now;
  logic         irq_kind;
  vec_addr_t    sel_addr;
  logic         wake_req;
  logic         vec_valid_r;
  vec_addr_t    vec_addr_r;
  irq_num_t     vec_irq_num_r;
  logic         vec_is_reset_r;
  logic         vec_is_trap_r;
  logic         wake_r;

  if (IRQ_COUNT > (1 << IRQ_W)) begin : g_chk
    $error("irq_vector_wakeup_map: request count exceeds number width");
  end

  // Source to request number
  always_comb begin
    src = '0;
    src[IRQ_TOP]    = top_level_pin_irq;
    src[IRQ_AWU]    = auto_wakeup_unit;
    src[IRQ_CLK]    = clock_ctrl_irq;
    src[IRQ_PORT_A] = port_a_pin_irq;
    src[IRQ_PORT_B] = port_b_pin_irq;
    src[IRQ_PORT_C] = port_c_pin_irq;
    src[IRQ_PORT_D] = port_d_pin_irq;
    src[IRQ_PORT_E] = port_e_pin_irq;
    src[IRQ_SPI]    = spi_end_irq;
    src[IRQ_ADV_UP] = |advanced_timer_upd_irq;
    src[IRQ_ADV_CC] = advanced_timer_cc_irq;
    src[IRQ_GEN_UP] = general_timer_upd_irq;
    src[IRQ_GEN_CC] = general_timer_cc_irq;
    src[IRQ_SER_TX] = serial_port_tx_irq;
    src[IRQ_SER_RX] = serial_port_rx_irq;
    src[IRQ_I2C]    = i2c_irq;
    src[IRQ_CONV]   = analog_converter_eoc_irq |
                      analog_converter_wdg_irq;
    src[IRQ_BASIC]  = basic_timer_upd_irq;
    src[IRQ_FLASH]  = end_of_programming |
                      protected_page_write_attempt;
  end

  assign pend_en   = pend_r & irq_enable & ~RESERVED_MASK;
  assign take      = (state_r == ST_OFFER) & vec_ack;
  assign irq_kind  = ~vec_is_reset_r & ~vec_is_trap_r;
  assign ack_clr   = irq_onehot(vec_irq_num_r) &
                     {IRQ_COUNT{take & irq_kind}};
  // Set wins over the acknowledge clear
  assign pend_nxt  = (pend_r & ~ack_clr) | (src & ~RESERVED_MASK);
  assign reset_pend_nxt = reset_pend_r & ~(take & vec_is_reset_r);
  assign trap_pend_nxt  = trap_req |
                          (trap_pend_r & ~(take & vec_is_trap_r));
  assign offer_now = (state_r == ST_IDLE) &
                     (reset_pend_r | trap_pend_r | pick_found);
  assign sel_addr  = reset_pend_r ? VEC_RESET :
                     trap_pend_r  ? VEC_TRAP  : irq_vector(pick_idx);

  irq_lowest_pick #(
    .N (IRQ_COUNT),
    .W (IRQ_W)
  ) u_pick (
    .req   (pend_en),
    .found (pick_found),
    .idx   (pick_idx)
  );

  irq_wake_gate u_wake (
    .src              (src),
    .port_a_pin1      (port_a_pin1),
    .halt_mode        (halt_mode),
    .active_halt_mode (active_halt_mode),
    .wake_req         (wake_req)
  );

  always_comb begin
    case (state_r)
      ST_IDLE:  state_nxt = offer_now ? ST_OFFER : ST_IDLE;
      ST_OFFER: state_nxt = vec_ack ? ST_IDLE : ST_OFFER;
      default:  state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_r      <= ST_IDLE;
      pend_r       <= '0;
      reset_pend_r <= 1'b1;
      trap_pend_r  <= 1'b0;
    end else begin
      state_r      <= state_nxt;
      pend_r       <= pend_nxt;
      reset_pend_r <= reset_pend_nxt;
      trap_pend_r  <= trap_pend_nxt;
    end
  end

  // Offer held steady until acknowledged
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      vec_valid_r    <= 1'b0;
      vec_addr_r     <= '0;
      vec_irq_num_r  <= '0;
      vec_is_reset_r <= 1'b0;
      vec_is_trap_r  <= 1'b0;
    end else if (offer_now) begin
      vec_valid_r    <= 1'b1;
      vec_addr_r     <= sel_addr;
      vec_irq_num_r  <= (reset_pend_r | trap_pend_r) ? '0 : pick_idx;
      vec_is_reset_r <= reset_pend_r;
      vec_is_trap_r  <= ~reset_pend_r & trap_pend_r;
    end else if (take) begin
      vec_valid_r    <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wake_r <= WAKE_AT_RESET;
    end else begin
      wake_r <= wake_req;
    end
  end

  assign vec_valid    = vec_valid_r;
  assign vec_addr     = vec_addr_r;
  assign vec_irq_num  = vec_irq_num_r;
  assign vec_is_reset = vec_is_reset_r;
  assign vec_is_trap  = vec_is_trap_r;
  assign wake         = wake_r;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  irq_set_t lower_than;
  irq_set_t no_wake_src;
  irq_set_t live_src;
  assign lower_than  = ~({IRQ_COUNT{1'b1}} << vec_irq_num_r);
  assign no_wake_src = src & ~WAKE_AHALT_MASK;
  assign live_src    = src & ~RESERVED_MASK;

  a_reset_vector: assert property (
    $rose(vec_valid_r) && vec_is_reset_r |-> vec_addr_r == VEC_RESET)
    else $error("reset offered at wrong vector");
  a_trap_vector: assert property (
    $rose(vec_valid_r) && vec_is_trap_r
      |-> vec_addr_r == VEC_TRAP && vec_irq_num_r == '0)
    else $error("trap offered at wrong vector");
  a_irq_vector: assert property (
    vec_valid_r && irq_kind
      |-> vec_addr_r == VEC_IRQ0 + (vec_addr_t'(vec_irq_num_r) << VEC_SHIFT))
    else $error("request offered at wrong vector");
  a_awu_halt: assert property (
    halt_mode && !active_halt_mode && src == irq_onehot(IRQ_AWU)
      |=> !wake_r)
    else $error("auto-wakeup woke from halt");
  a_awu_ahalt: assert property (
    active_halt_mode && auto_wakeup_unit |=> wake_r)
    else $error("auto-wakeup missed active-halt");
  a_nowake_src: assert property (
    (halt_mode || active_halt_mode) && no_wake_src != '0
      && (src & WAKE_AHALT_MASK) == '0 |=> !wake_r)
    else $error("non-waking source woke the core");
  a_port_wake: assert property (
    (halt_mode || active_halt_mode) && port_d_pin_irq |=> wake_r)
    else $error("port interrupt failed to wake");
  a_pin1_wake: assert property (
    halt_mode && src == irq_onehot(IRQ_PORT_A) && port_a_pin1
      |=> !wake_r)
    else $error("port A pin 1 woke the core");
  a_spi_i2c_wake: assert property (
    halt_mode && (i2c_irq || spi_end_irq) |=> wake_r)
    else $error("serial interface failed to wake");
  a_reserved_slot: assert property (
    vec_valid_r && irq_kind
      |-> (irq_onehot(vec_irq_num_r) & RESERVED_MASK) == '0)
    else $error("reserved slot offered");
  a_lowest_first: assert property (
    $rose(vec_valid_r) && irq_kind
      |-> ($past(pend_en) & lower_than) == '0)
    else $error("higher request served before lower");
  a_offer_hold: assert property (
    vec_valid_r && !vec_ack |=> vec_valid_r && $stable(vec_addr_r))
    else $error("offer changed before acknowledge");
  a_offer_latency: assert property (
    state_r == ST_IDLE && !vec_valid_r && pick_found |=> vec_valid_r)
    else $error("pending request not offered");

  // Rank, pending and non-waking source checks
  a_reserved_pend: assert property (
    (pend_r & RESERVED_MASK) == '0)
    else $error("reserved request became pending");
  a_clk_nowake: assert property (
    (halt_mode || active_halt_mode) && src == irq_onehot(IRQ_CLK)
      |=> !wake_r)
    else $error("clock controller woke the core");
  a_timer_nowake: assert property (
    (halt_mode || active_halt_mode) && src != '0 &&
      (src & ~(irq_onehot(IRQ_GEN_UP) | irq_onehot(IRQ_GEN_CC))) == '0
      |=> !wake_r)
    else $error("general timer woke the core");
  a_serial_nowake: assert property (
    (halt_mode || active_halt_mode) && src != '0 &&
      (src & ~(irq_onehot(IRQ_SER_TX) | irq_onehot(IRQ_SER_RX))) == '0
      |=> !wake_r)
    else $error("serial port woke the core");
  a_trap_rank: assert property (
    state_r == ST_IDLE && trap_pend_r && !reset_pend_r
      |=> vec_valid_r && vec_is_trap_r)
    else $error("trap not offered ahead of requests");
  a_reset_rank: assert property (
    state_r == ST_IDLE && reset_pend_r |=> vec_valid_r && vec_is_reset_r)
    else $error("reset vector not offered first");
  a_ack_clear: assert property (
    take && irq_kind && (src & ack_clr) == '0
      |=> (pend_r & $past(ack_clr)) == '0)
    else $error("served request stayed pending");
  a_set_wins: assert property (
    live_src != '0 |=> (pend_r & $past(live_src)) == $past(live_src))
    else $error("source event lost");

  c_reset_taken: cover property (vec_is_reset_r && take);
  c_trap_taken: cover property (vec_is_trap_r && take);
  c_irq_taken: cover property (irq_kind && take && vec_irq_num_r != '0);
  c_wake_halt: cover property (halt_mode ##1 wake_r);
  c_wake_ahalt: cover property (active_halt_mode && auto_wakeup_unit ##1 wake_r);
endmodule : irq_vector_wakeup_map
`default_nettype wire

/* testbench/core_model.sv */
// Behavioural core that takes offered vectors after a set delay
`default_nettype none
module core_model
  import irq_map_pkg::*;
(
  // Clock and reset
  input  wire logic                   ref_clk,
  input  wire logic                   sys_rst,
  // Vector offer
  input  wire logic                   vec_valid,
  input  wire irq_map_pkg::vec_addr_t vec_addr,
  input  wire irq_map_pkg::irq_num_t  vec_irq_num,
  input  wire logic                   vec_is_reset,
  input  wire logic                   vec_is_trap,
  input  wire logic [3:0]             ack_dly,
  output logic                        vec_ack,
  // Last vector taken
  output logic [7:0]                  got_cnt,
  output irq_map_pkg::vec_addr_t      got_addr,
  output irq_map_pkg::irq_num_t       got_num,
  output logic [1:0]                  got_kind
);
  timeunit 1ns;
  timeprecision 1ps;
  import irq_map_pkg::*;
  logic [3:0] wait_r;
  // Ack held until the edge that takes it
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      vec_ack <= 1'b0;
      wait_r  <= 4'h0;
      got_cnt <= 8'h00;
    end else if (vec_valid && vec_ack) begin
      vec_ack  <= 1'b0;
      wait_r   <= 4'h0;
      got_cnt  <= got_cnt + 8'h01;
      got_addr <= vec_addr;
      got_num  <= vec_irq_num;
      got_kind <= {vec_is_reset, vec_is_trap};
    end else if (vec_valid) begin
      wait_r  <= wait_r + 4'h1;
      vec_ack <= (wait_r >= ack_dly);
    end else begin
      vec_ack <= 1'b0;
      wait_r  <= 4'h0;
    end
  end
endmodule : core_model
`default_nettype wire

/* testbench/testbench.sv */
// Self-checking bench for the interrupt vector and wakeup map
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import irq_map_pkg::*;
  // Request number behind each source line
  localparam int REQ_OF [25] = '{0, 1, 2, 3, 4, 5, 6, 7, 10, 11, 11, 11, 11,
                                 11, 12, 13, 14, 17, 18, 19, 22, 22, 24, 24,
                                 23};
  localparam int CEILING = 20000;
  logic        ref_clk, sys_rst, port_a_pin1, trap_req;
  logic        halt_mode, active_halt_mode;
  logic [24:0] ln;
  irq_set_t    irq_enable;
  logic [3:0]  ack_dly;
  logic        vec_valid, vec_ack, vec_is_reset, vec_is_trap, wake;
  vec_addr_t   vec_addr, got_addr;
  irq_num_t    vec_irq_num, got_num;
  logic [7:0]  got_cnt, seen;
  logic [1:0]  got_kind;
  int          failures, n_tests, cycles;

  irq_vector_wakeup_map uut (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .top_level_pin_irq(ln[0]),
    .auto_wakeup_unit(ln[1]), .clock_ctrl_irq(ln[2]),
    .port_a_pin_irq(ln[3]), .port_a_pin1(port_a_pin1),
    .port_b_pin_irq(ln[4]), .port_c_pin_irq(ln[5]),
    .port_d_pin_irq(ln[6]), .port_e_pin_irq(ln[7]), .spi_end_irq(ln[8]),
    .serial_port_tx_irq(ln[17]), .serial_port_rx_irq(ln[18]),
    .i2c_irq(ln[19]), .advanced_timer_upd_irq(ln[13:9]),
    .advanced_timer_cc_irq(ln[14]), .general_timer_upd_irq(ln[15]),
    .general_timer_cc_irq(ln[16]), .basic_timer_upd_irq(ln[24]),
    .analog_converter_eoc_irq(ln[20]), .analog_converter_wdg_irq(ln[21]),
    .end_of_programming(ln[22]), .protected_page_write_attempt(ln[23]),
    .irq_enable(irq_enable), .trap_req(trap_req), .halt_mode(halt_mode),
    .active_halt_mode(active_halt_mode), .vec_ack(vec_ack),
    .vec_valid(vec_valid), .vec_addr(vec_addr), .vec_irq_num(vec_irq_num),
    .vec_is_reset(vec_is_reset), .vec_is_trap(vec_is_trap), .wake(wake));

  core_model core (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .vec_valid(vec_valid),
    .vec_addr(vec_addr), .vec_irq_num(vec_irq_num),
    .vec_is_reset(vec_is_reset), .vec_is_trap(vec_is_trap),
    .ack_dly(ack_dly), .vec_ack(vec_ack), .got_cnt(got_cnt),
    .got_addr(got_addr), .got_num(got_num), .got_kind(got_kind));

  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  task automatic conclude;
    if (failures == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : conclude

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == CEILING) begin
      failures++;
      conclude();
    end
  end

  task automatic chk_bit(input logic a, input logic e, input string m);
    n_tests++;
    if (a !== e) begin
      failures++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask : chk_bit

  task automatic chk_addr(input vec_addr_t a, input vec_addr_t e);
    n_tests++;
    if (a !== e) begin
      failures++;
      $display("CHECK FAILED %0t address %h not %h", $time, a, e);
    end
  endtask : chk_addr

  task automatic chk_num(input irq_num_t a, input irq_num_t e);
    n_tests++;
    if (a !== e) begin
      failures++;
      $display("CHECK FAILED %0t number %0d not %0d", $time, a, e);
    end
  endtask : chk_num

  // Waits for the core to take the next vector, then judges it
  task automatic take_vec(input vec_addr_t a, input irq_num_t n,
                          input logic [1:0] k);
    int t;
    t = 0;
    while (got_cnt === seen && t < 60) begin
      @(negedge ref_clk);
      t++;
    end
    chk_bit(got_cnt !== seen, 1'b1, "no vector taken");
    seen = got_cnt;
    chk_addr(got_addr, a);
    chk_num(got_num, n);
    chk_bit(got_kind[1], k[1], "reset flag");
    chk_bit(got_kind[0], k[0], "trap flag");
  endtask : take_vec

  task automatic do_reset;
    @(negedge ref_clk);
    sys_rst = 1'b1;
    repeat (4) @(negedge ref_clk);
    chk_bit(wake, 1'b1, "wake in reset");
    chk_bit(vec_valid, 1'b0, "offer in reset");
    seen = 8'h00;
    sys_rst = 1'b0;
    take_vec(24'h008000, 5'h00, 2'b10);
  endtask : do_reset

  // One source through halt, active-halt, then its vector
  task automatic run_src(input int l, input logic p1);
    int   n;
    logic wh;
    n = REQ_OF[l];
    wh = (n inside {3, 4, 5, 6, 7, 10, 19}) && !p1;
    @(negedge ref_clk);
    ln[l] = 1'b1;
    port_a_pin1 = p1;
    halt_mode = 1'b1;
    @(negedge ref_clk);
    chk_bit(wake, wh, "halt wake");
    halt_mode = 1'b0;
    active_halt_mode = 1'b1;
    @(negedge ref_clk);
    chk_bit(wake, wh || n == 1, "active halt wake");
    active_halt_mode = 1'b0;
    ln[l] = 1'b0;
    port_a_pin1 = 1'b0;
    @(negedge ref_clk);
    chk_bit(wake, 1'b0, "wake without mode");
    take_vec(24'h008008 + 24'(4 * n), 5'(n), 2'b00);
  endtask : run_src

  task automatic trap_first;
    @(negedge ref_clk);
    trap_req = 1'b1;
    halt_mode = 1'b1;
    @(negedge ref_clk);
    chk_bit(wake, 1'b0, "trap woke core");
    trap_req = 1'b0;
    halt_mode = 1'b0;
    ln[4] = 1'b1;
    @(negedge ref_clk);
    ln[4] = 1'b0;
    take_vec(24'h008004, 5'h00, 2'b01);
    take_vec(24'h008018, 5'h04, 2'b00);
  endtask : trap_first

  task automatic prio_order;
    @(negedge ref_clk);
    irq_enable = ~25'h0000020;
    ln[24] = 1'b1;
    ln[5] = 1'b1;
    ln[15] = 1'b1;
    @(negedge ref_clk);
    ln = '0;
    take_vec(24'h00803c, 5'h0d, 2'b00);
    take_vec(24'h008064, 5'h17, 2'b00);
    irq_enable = '1;
    take_vec(24'h00801c, 5'h05, 2'b00);
  endtask : prio_order

  initial begin
    sys_rst = 1'b1;
    ln = '0;
    trap_req = 1'b0;
    halt_mode = 1'b0;
    active_halt_mode = 1'b0;
    port_a_pin1 = 1'b0;
    irq_enable = '1;
    ack_dly = 4'h0;
    failures = 0;
    n_tests = 0;
    cycles = 0;
    seen = 8'h00;
    do_reset();
    ack_dly = 4'h8;
    for (int i = 0; i < 25; i++) begin
      run_src(i, 1'b0);
    end
    run_src(3, 1'b1);
    trap_first();
    prio_order();
    do_reset();
    conclude();
  end
endmodule : testbench
`default_nettype wire
